//--- hdl/actr_pkg.sv
// Constants and types shared by the accumulator-to-control-register decode logic
package actr_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int OP_W      = 10;
  localparam int NIB_W     = 4;
  localparam int RELOAD_W  = 8;
  localparam int NUM_TGT   = 6;
  localparam int SYNC_LEN  = 2;

  // ---------------------------------------------------------------------------
  // Opcodes of the group
  // ---------------------------------------------------------------------------
  localparam logic [OP_W-1:0] OPC_PULLUP_ONE = 10'h22E;
  localparam logic [OP_W-1:0] OPC_PULLUP_TWO = 10'h22F;
  localparam logic [OP_W-1:0] OPC_RELOAD     = 10'h23F;
  localparam logic [OP_W-1:0] OPC_IRQ_ONE    = 10'h03F;
  // Encodings below are not fixed by the core spec; defaults only
  localparam logic [OP_W-1:0] OPC_IRQ_TWO    = 10'h03E;
  localparam logic [OP_W-1:0] OPC_TIMER_ONE  = 10'h00E;

  // ---------------------------------------------------------------------------
  // Target indices and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_PULLUP_ONE = 3'b000,
    TGT_PULLUP_TWO = 3'b001,
    TGT_RELOAD     = 3'b010,
    TGT_IRQ_ONE    = 3'b011,
    TGT_IRQ_TWO    = 3'b100,
    TGT_TIMER_ONE  = 3'b101,
    TGT_NONE       = 3'b110
  } actr_tgt_t;

  localparam logic [NIB_W-1:0]    NIB_RST    = 4'h0;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 8'h00;

endpackage

//--- hdl/actr_decode.sv
// Opcode decoder: full 10-bit match to a one-hot target select
`timescale 1ns/1ps
module actr_decode
  import actr_pkg::*;
(
  input  wire logic                  instrValid,
  input  wire logic [actr_pkg::OP_W-1:0]    instrWord,
  output logic      [actr_pkg::NUM_TGT-1:0] tgtSel,
  output actr_pkg::actr_tgt_t               tgtCode
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  always_comb begin
    tgtCode = TGT_NONE;
    case (instrWord)
      OPC_PULLUP_ONE: tgtCode = TGT_PULLUP_ONE;
      OPC_PULLUP_TWO: tgtCode = TGT_PULLUP_TWO;
      OPC_RELOAD:     tgtCode = TGT_RELOAD;
      OPC_IRQ_ONE:    tgtCode = TGT_IRQ_ONE;
      OPC_IRQ_TWO:    tgtCode = TGT_IRQ_TWO;
      OPC_TIMER_ONE:  tgtCode = TGT_TIMER_ONE;
      default:        tgtCode = TGT_NONE;
    endcase
  end

  // Exact match only; invalid slots never select
  always_comb begin
    tgtSel = '0;
    if (instrValid && (tgtCode != TGT_NONE)) begin
      tgtSel[tgtCode] = 1'b1; // see RL7
    end
  end

endmodule

//--- hdl/actr_core.sv
// Execute logic for accumulator-to-control-register transfer instructions
//
// Behaviour
// RL1: Opcode 1000101110 loads pull-up control one
// RL2: Opcode 1000101111 loads pull-up control two
// RL3: Opcode 1000111111 loads reload from B, accumulator
// RL4: Opcode 0000111111 loads interrupt control one
// RL5: Own opcode loads interrupt control two
// RL6: Own opcode loads timer control one
// RL7: Exact match, single strobe, same cycle
`timescale 1ns/1ps
module actr_core
  import actr_pkg::*;
(
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  input  wire logic                              instrValid,
  input  wire logic [actr_pkg::OP_W-1:0]         instrWord,
  input  wire logic [actr_pkg::NIB_W-1:0]        accum,
  input  wire logic [actr_pkg::NIB_W-1:0]        regB,
  output logic      [actr_pkg::NUM_TGT-1:0]      wrStrobe,
  output logic                                   opHit,
  output logic                                   skipNext,
  output logic                                   carryWrEn,
  output logic      [actr_pkg::NIB_W-1:0]        pullupCtrlOne,
  output logic      [actr_pkg::NIB_W-1:0]        pullupCtrlTwo,
  output logic      [actr_pkg::RELOAD_W-1:0]     reloadRegOne,
  output logic      [actr_pkg::NIB_W-1:0]        irqCtrlOne,
  output logic      [actr_pkg::NIB_W-1:0]        irqCtrlTwo,
  output logic      [actr_pkg::NIB_W-1:0]        timerCtrlOne
);
  import actr_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [SYNC_LEN-1:0] rstSync;
  logic [SYNC_LEN-1:0] next_rstSync;
  logic                rstN;

  always_comb begin
    next_rstSync = {rstSync[SYNC_LEN-2:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= '0;
    end else begin
      rstSync <= next_rstSync;
    end
  end

  assign rstN = rstSync[SYNC_LEN-1];

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic [NUM_TGT-1:0] tgtSel;
  actr_tgt_t          tgtCode;

  actr_decode u_decode (
    .instrValid (instrValid),
    .instrWord  (instrWord),
    .tgtSel     (tgtSel),
    .tgtCode    (tgtCode)
  );

  // Strobes held off until reset has fully left the core
  assign wrStrobe = rstN ? tgtSel : '0; // see RL7
  assign opHit    = |wrStrobe;

  // Whole group neither skips nor touches carry
  assign skipNext  = 1'b0; // see RL1
  assign carryWrEn = 1'b0; // see RL6

  // ---------------------------------------------------------------------------
  // Target storage
  // ---------------------------------------------------------------------------
  // Every target is eight bits wide so one loop serves all; nibble targets
  // keep their upper half at zero and expose only the low nibble.
  logic [RELOAD_W-1:0] store [NUM_TGT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TGT; gi++) begin : g_tgt
      // Reload keeps its own reset constant; nibble targets clear to zero
      localparam logic [RELOAD_W-1:0] RST_VAL =
        (gi == int'(TGT_RELOAD)) ? RELOAD_RST : {NIB_RST, NIB_RST};
      logic [RELOAD_W-1:0] next_store;
      logic [RELOAD_W-1:0] loadVal;

      always_comb begin
        if (gi == int'(TGT_RELOAD)) begin
          loadVal = {regB, accum}; // see RL3
        end else begin
          loadVal = {NIB_RST, accum}; // see RL1
        end
        next_store = wrStrobe[gi] ? loadVal : store[gi]; // see RL7
      end

      always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          store[gi] <= RST_VAL;
        end else begin
          store[gi] <= next_store;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Register outputs
  // ---------------------------------------------------------------------------
  assign pullupCtrlOne = store[TGT_PULLUP_ONE][NIB_W-1:0]; // see RL1
  assign pullupCtrlTwo = store[TGT_PULLUP_TWO][NIB_W-1:0]; // see RL2
  assign reloadRegOne  = store[TGT_RELOAD];                // see RL3
  assign irqCtrlOne    = store[TGT_IRQ_ONE][NIB_W-1:0];    // see RL4
  assign irqCtrlTwo    = store[TGT_IRQ_TWO][NIB_W-1:0];    // see RL5
  assign timerCtrlOne  = store[TGT_TIMER_ONE][NIB_W-1:0];  // see RL6

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Checks start one edge after rstN rises: at the release edge itself the
  // sampled strobes still show reset, which would trip the load checks
  logic chkArmed;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      chkArmed <= 1'b0;
    end else begin
      chkArmed <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!chkArmed);

  logic [NUM_TGT-1:0] pastHit;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pastHit <= '0;
    end else begin
      pastHit <= wrStrobe;
    end
  end

  a_pullup_one_load: assert property ( // see RL1
    instrValid && instrWord == OPC_PULLUP_ONE
      |-> wrStrobe[TGT_PULLUP_ONE] ##1 pullupCtrlOne == $past(accum))
    else $error("pull-up one not loaded from accumulator");

  a_pullup_two_load: assert property ( // see RL2
    instrValid && instrWord == OPC_PULLUP_TWO
      |=> pullupCtrlTwo == $past(accum) && pastHit == 6'h02)
    else $error("pull-up two not loaded from accumulator");

  a_reload_pair_load: assert property ( // see RL3
    instrValid && instrWord == OPC_RELOAD
      |=> reloadRegOne[7:4] == $past(regB) && reloadRegOne[3:0] == $past(accum))
    else $error("reload register halves wrong");

  a_irq_one_load: assert property ( // see RL4
    instrValid && instrWord == OPC_IRQ_ONE
      |=> irqCtrlOne == $past(accum) && $stable(irqCtrlTwo))
    else $error("interrupt control one not loaded");

  a_irq_two_load: assert property ( // see RL5
    instrValid && instrWord == OPC_IRQ_TWO
      |=> irqCtrlTwo == $past(accum) && $stable(irqCtrlOne))
    else $error("interrupt control two not loaded");

  a_timer_one_load: assert property ( // see RL6
    instrValid && instrWord == OPC_TIMER_ONE
      |=> timerCtrlOne == $past(accum) && $stable(reloadRegOne))
    else $error("timer control one not loaded");

  a_strobe_one_hot: assert property ( // see RL7
    $onehot0(wrStrobe) && (opHit == (instrValid && tgtCode != TGT_NONE)))
    else $error("strobe not exactly one for a matched opcode");

  // Each strobe against its own opcode, not the decoder's table
  a_strobe_matches_op: assert property ( // see RL7
    (wrStrobe[TGT_PULLUP_ONE] == (instrValid && instrWord == OPC_PULLUP_ONE))
      && (wrStrobe[TGT_PULLUP_TWO] == (instrValid && instrWord == OPC_PULLUP_TWO))
      && (wrStrobe[TGT_RELOAD] == (instrValid && instrWord == OPC_RELOAD))
      && (wrStrobe[TGT_IRQ_ONE] == (instrValid && instrWord == OPC_IRQ_ONE))
      && (wrStrobe[TGT_IRQ_TWO] == (instrValid && instrWord == OPC_IRQ_TWO))
      && (wrStrobe[TGT_TIMER_ONE] == (instrValid && instrWord == OPC_TIMER_ONE)))
    else $error("strobe does not follow its opcode");

  // Watched through reset itself, so it carries its own disable
  a_reset_quiet: assert property ( // see RL7
    @(posedge ref_clk) disable iff (1'b0)
    !rstN |-> wrStrobe == '0 && !opHit && reloadRegOne == RELOAD_RST
      && pullupCtrlOne == NIB_RST && pullupCtrlTwo == NIB_RST
      && irqCtrlOne == NIB_RST && irqCtrlTwo == NIB_RST && timerCtrlOne == NIB_RST)
    else $error("write or nonzero value while core held in reset");

  a_idle_holds_all: assert property ( // see RL7
    !opHit |=> $stable(pullupCtrlOne) && $stable(pullupCtrlTwo)
      && $stable(reloadRegOne) && $stable(irqCtrlOne)
      && $stable(irqCtrlTwo) && $stable(timerCtrlOne))
    else $error("register changed without a strobe");

  a_no_skip_carry: assert property ( // see RL1
    opHit ##1 opHit |-> !skipNext && !carryWrEn)
    else $error("group raised skip or carry write");

  // ---------------------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------------------
  c_back_to_back: cover property (
    wrStrobe[TGT_PULLUP_ONE] ##1 wrStrobe[TGT_PULLUP_TWO]);
  c_pullup_then_reload: cover property (
    wrStrobe[TGT_PULLUP_TWO] ##1 wrStrobe[TGT_RELOAD]);
  c_reload_load: cover property (
    wrStrobe[TGT_RELOAD] && regB != accum);
  c_irq_then_timer: cover property (
    wrStrobe[TGT_IRQ_ONE] ##[1:4] wrStrobe[TGT_TIMER_ONE]);
  c_unmatched_valid: cover property (
    instrValid && !opHit);

endmodule

//--- tb/tb_top.sv
// Self-checking bench for the accumulator-to-control-register execute logic
`timescale 1ns/1ps
module tb_top;
  import actr_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                ref_clk;
  logic                rst_b;
  logic                instrValid;
  logic [OP_W-1:0]     instrWord;
  logic [NIB_W-1:0]    accum;
  logic [NIB_W-1:0]    regB;
  logic [NUM_TGT-1:0]  wrStrobe;
  logic                opHit;
  logic                skipNext;
  logic                carryWrEn;
  logic [NIB_W-1:0]    pullupCtrlOne;
  logic [NIB_W-1:0]    pullupCtrlTwo;
  logic [RELOAD_W-1:0] reloadRegOne;
  logic [NIB_W-1:0]    irqCtrlOne;
  logic [NIB_W-1:0]    irqCtrlTwo;
  logic [NIB_W-1:0]    timerCtrlOne;
  logic [7:0]          model [NUM_TGT];
  logic [OP_W-1:0]     opTab [NUM_TGT];
  int                  err_count;
  int                  compares;

  actr_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .instrValid(instrValid),
    .instrWord(instrWord), .accum(accum), .regB(regB), .wrStrobe(wrStrobe),
    .opHit(opHit), .skipNext(skipNext), .carryWrEn(carryWrEn),
    .pullupCtrlOne(pullupCtrlOne), .pullupCtrlTwo(pullupCtrlTwo),
    .reloadRegOne(reloadRegOne), .irqCtrlOne(irqCtrlOne), .irqCtrlTwo(irqCtrlTwo),
    .timerCtrlOne(timerCtrlOne));

  always #2.5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD time=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Every target is compared, so a stray write anywhere shows up
  task automatic chk_regs();
    chk({4'h0, pullupCtrlOne}, model[0]);
    chk({4'h0, pullupCtrlTwo}, model[1]);
    chk(reloadRegOne, model[2]);
    chk({4'h0, irqCtrlOne}, model[3]);
    chk({4'h0, irqCtrlTwo}, model[4]);
    chk({4'h0, timerCtrlOne}, model[5]);
  endtask

  // Leaves the inputs driven so the next call runs back to back
  task automatic do_op(input int tgt, input logic [3:0] a, input logic [3:0] b);
    instrValid = 1'b1;
    instrWord = opTab[tgt];
    accum = a;
    regB = b;
    #1;
    chk({2'h0, wrStrobe}, 8'h01 << tgt);
    chk({7'h00, opHit}, 8'h01);
    chk({6'h00, skipNext, carryWrEn}, 8'h00);
    model[tgt] = (tgt == 2) ? {b, a} : {4'h0, a};
    @(posedge ref_clk);
    #1;
    chk_regs();
  endtask

  task automatic no_op(input logic v, input logic [OP_W-1:0] op);
    instrValid = v;
    instrWord = op;
    accum = ~accum;
    regB = ~regB;
    #1;
    chk({2'h0, wrStrobe}, 8'h00);
    chk({7'h00, opHit}, 8'h00);
    @(posedge ref_clk);
    #1;
    chk_regs();
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    instrValid = 1'b1;
    instrWord = 10'h22E;
    accum = 4'hF;
    regB = 4'hF;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({2'h0, wrStrobe}, 8'h00);
    chk_regs();
    rst_b = 1'b1;
    instrValid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_regs();
  endtask

  task automatic t_each();
    do_op(0, 4'h5, 4'h9);
    do_op(1, 4'hA, 4'h6);
    do_op(2, 4'h5, 4'hA);
    do_op(3, 4'h3, 4'hC);
    do_op(4, 4'hC, 4'h3);
    do_op(5, 4'h9, 4'h6);
    do_op(2, 4'hF, 4'h1);
    do_op(0, 4'hE, 4'h7);
  endtask

  // One-bit neighbours of each opcode that are not opcodes themselves must do nothing
  task automatic t_miss();
    logic [OP_W-1:0] op;
    bit              clash;
    for (int t = 0; t < NUM_TGT; t++) begin
      for (int k = 0; k < OP_W; k++) begin
        op = opTab[t] ^ (10'h001 << k);
        clash = 1'b0;
        foreach (opTab[j]) if (opTab[j] === op) clash = 1'b1;
        if (!clash) no_op(1'b1, op);
      end
      no_op(1'b0, opTab[t]);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    instrValid = 1'b0;
    instrWord = 10'h000;
    accum = 4'h0;
    regB = 4'h0;
    err_count = 0;
    compares = 0;
    opTab = '{10'h22E, 10'h22F, 10'h23F, 10'h03F, OPC_IRQ_TWO, OPC_TIMER_ONE};
    foreach (model[i]) model[i] = 8'h00;
    t_reset();
    t_each();
    t_miss();
    final_report();
  end

  // Tests need about 74 cycles; 1000 leaves ample margin
  initial begin
    #5000;
    err_count++;
    final_report();
  end
endmodule
